// *** vof_formatter.sv ***
// video output formatter: port packing, embedded timing codes, range clamp
`default_nettype none
module vof_formatter
  import vof_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire logic      output_pixel_clock,
  input  wire vof_pix_t  pix_in,
  input  wire logic      hsync_in,
  input  wire logic      vsync_in,
  input  wire logic      field_in,
  input  wire logic      reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output vof_word_t      grn_out,
  output vof_word_t      blue_output_port,
  output vof_word_t      red_out,
  output logic           red_oe,
  output logic           horizontal_sync_output,
  output logic           active_video_window
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  fmt_q;
  logic [15:0] start_q;
  logic [15:0] stop_q;
  logic [7:0]  vst_q  [2];
  logic [7:0]  vdur_q [2];
  logic [7:0]  fst_q  [2];
  logic [7:0]  rdata_d;
  vof_cfg_t    cfg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fmt_q   <= VOF_RST_FMT;
      start_q <= VOF_RST_START;
      stop_q  <= VOF_RST_STOP;
      vst_q   <= '{VOF_RST_VST, VOF_RST_VST};
      vdur_q  <= '{VOF_RST_VDUR, VOF_RST_VDUR};
      fst_q   <= '{VOF_RST_FST, VOF_RST_FST};
    end else if (reg_wr) begin
      case (reg_addr)
        VOF_ADDR_FMT:      fmt_q         <= reg_wdata;
        VOF_ADDR_START_LO: start_q[7:0]  <= reg_wdata;
        VOF_ADDR_START_HI: start_q[15:8] <= reg_wdata;
        VOF_ADDR_STOP_LO:  stop_q[7:0]   <= reg_wdata;
        VOF_ADDR_STOP_HI:  stop_q[15:8]  <= reg_wdata;
        VOF_ADDR_VST_F0:   vst_q[0]      <= reg_wdata;
        VOF_ADDR_VST_F1:   vst_q[1]      <= reg_wdata;
        VOF_ADDR_VDUR_F0:  vdur_q[0]     <= reg_wdata;
        VOF_ADDR_VDUR_F1:  vdur_q[1]     <= reg_wdata;
        VOF_ADDR_FST_F0:   fst_q[0]      <= reg_wdata;
        VOF_ADDR_FST_F1:   fst_q[1]      <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      VOF_ADDR_FMT:      rdata_d = fmt_q;
      VOF_ADDR_START_LO: rdata_d = start_q[7:0];
      VOF_ADDR_START_HI: rdata_d = start_q[15:8];
      VOF_ADDR_STOP_LO:  rdata_d = stop_q[7:0];
      VOF_ADDR_STOP_HI:  rdata_d = stop_q[15:8];
      VOF_ADDR_VST_F0:   rdata_d = vst_q[0];
      VOF_ADDR_VST_F1:   rdata_d = vst_q[1];
      VOF_ADDR_VDUR_F0:  rdata_d = vdur_q[0];
      VOF_ADDR_VDUR_F1:  rdata_d = vdur_q[1];
      VOF_ADDR_FST_F0:   rdata_d = fst_q[0];
      VOF_ADDR_FST_F1:   rdata_d = fst_q[1];
      default:           rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  assign cfg.embed_en  = fmt_q[VOF_FMT_EMB_BIT];
  assign cfg.mode422   = fmt_q[VOF_FMT_MODE_BIT];
  assign cfg.range_sel = fmt_q[VOF_FMT_RANGE_LSB+:2];

  // ----------------------------------------------------------------
  // pixel clock sampling
  // ----------------------------------------------------------------
  // the pixel clock is slow against sys_clk, so its rising edge is a strobe
  logic pclk_s1_q;
  logic pclk_s2_q;
  logic pclk_s3_q;
  logic pix_stb;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pclk_s1_q <= 1'b0;
      pclk_s2_q <= 1'b0;
      pclk_s3_q <= 1'b0;
    end else begin
      pclk_s1_q <= output_pixel_clock;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
    end
  end
  assign pix_stb = pclk_s2_q & ~pclk_s3_q;

  // ----------------------------------------------------------------
  // pixel and line counting
  // ----------------------------------------------------------------
  logic [15:0] pix_cnt_q;
  logic [10:0] line_cnt_q;
  logic        hs_prev_q;
  logic        vs_prev_q;
  logic        hs_rise;
  logic        f_q;
  logic        v_d;
  logic        v_q;
  logic [8:0]  vend;

  assign hs_rise = hsync_in & ~hs_prev_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pix_cnt_q  <= 16'h0000;
      line_cnt_q <= 11'h000;
      hs_prev_q  <= 1'b0;
      vs_prev_q  <= 1'b0;
    end else if (pix_stb) begin
      hs_prev_q <= hsync_in;
      pix_cnt_q <= hs_rise ? 16'h0000 : pix_cnt_q + 16'h0001;
      if (hs_rise) begin
        vs_prev_q  <= vsync_in;
        line_cnt_q <= (vsync_in & ~vs_prev_q) ? 11'h000 : line_cnt_q + 11'h001;
      end
    end
  end

  // vertical flag holds from the blanking start line for its duration
  assign vend = {1'b0, vst_q[field_in]} + {1'b0, vdur_q[field_in]};
  assign v_d  = (line_cnt_q >= {3'h0, vst_q[field_in]}) && (line_cnt_q < {2'h0, vend});

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      f_q <= 1'b0;
      v_q <= 1'b0;
    end else if (pix_stb) begin
      v_q <= v_d;
      if (line_cnt_q == {3'h0, fst_q[field_in]}) begin
        f_q <= field_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // active video window
  // ----------------------------------------------------------------
  // start must absorb the internal delay of about VOF_PDELAY_TYP pixels
  logic active_video_window_d;
  always_comb begin
    if (stop_q < start_q) begin
      active_video_window_d = (pix_cnt_q >= start_q) || (pix_cnt_q < stop_q);
    end else begin
      active_video_window_d = (pix_cnt_q >= start_q) && (pix_cnt_q < stop_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_video_window <= 1'b0;
    end else if (pix_stb) begin
      active_video_window <= active_video_window_d;
    end
  end

  // ----------------------------------------------------------------
  // timing code sequencer
  // ----------------------------------------------------------------
  vof_state_t st_q;
  logic [1:0] word_q;
  logic       eav_q;
  logic [3:0] prot;
  vof_word_t  code_word;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q   <= VOF_ST_IDLE;
      word_q <= 2'h0;
      eav_q  <= 1'b0;
    end else if (pix_stb) begin
      case (st_q)
        VOF_ST_IDLE: begin
          if (cfg.embed_en && (active_video_window_d != active_video_window)) begin
            st_q   <= VOF_ST_CODE;
            word_q <= 2'h0;
            eav_q  <= active_video_window;
          end
        end
        VOF_ST_CODE: begin
          word_q <= word_q + 2'h1;
          if (word_q == VOF_CODE_LAST) begin
            st_q <= VOF_ST_IDLE;
          end
        end
        default: st_q <= VOF_ST_IDLE;
      endcase
    end
  end

  assign prot = {v_q ^ eav_q, f_q ^ eav_q, f_q ^ v_q, f_q ^ v_q ^ eav_q};
  always_comb begin
    case (word_q)
      2'h0:    code_word = VOF_CODE_ONES;
      2'h1:    code_word = VOF_CODE_ZERO;
      2'h2:    code_word = VOF_CODE_ZERO;
      default: code_word = {1'b1, f_q, v_q, eav_q, prot, 2'b00};
    endcase
  end

  // ----------------------------------------------------------------
  // data pipeline
  // ----------------------------------------------------------------
  vof_pix_t dly_q [VOF_HB_TAPS];
  vof_pix_t q422_q [VOF_LAT_422-VOF_HB_CENTER-1];
  logic [VOF_HB_TAPS-1:0][9:0] cb_taps;
  logic [VOF_HB_TAPS-1:0][9:0] cr_taps;
  vof_word_t cb_filt;
  vof_word_t cr_filt;
  logic [VOF_LAT_HS-1:0] hs_sh_q;

  for (genvar k = 0; k < VOF_HB_TAPS; k++) begin : g_taps
    assign cb_taps[k] = dly_q[k].b;
    assign cr_taps[k] = dly_q[k].r;
  end

  vof_halfband u_hb_cb (.taps(cb_taps), .filt(cb_filt));
  vof_halfband u_hb_cr (.taps(cr_taps), .filt(cr_filt));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dly_q   <= '{default: '0};
      q422_q  <= '{default: '0};
      hs_sh_q <= '0;
    end else if (pix_stb) begin
      dly_q[0]  <= pix_in;
      q422_q[0] <= '{r: cr_filt, g: dly_q[VOF_HB_CENTER].g, b: cb_filt};
      hs_sh_q   <= {hs_sh_q[VOF_LAT_HS-2:0], hsync_in};
      for (int k = 1; k < VOF_HB_TAPS; k++) begin
        dly_q[k] <= dly_q[k-1];
      end
      for (int k = 1; k < VOF_LAT_422-VOF_HB_CENTER-1; k++) begin
        q422_q[k] <= q422_q[k-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // range clamp and output stage
  // ----------------------------------------------------------------
  function automatic vof_word_t vof_clamp(input vof_word_t v, input logic [1:0] rs, input logic luma);
    vof_word_t lo;
    vof_word_t hi;
    lo = VOF_CODE_ZERO;
    hi = VOF_CODE_ONES;
    if (rs == VOF_RNG_EXT) begin
      lo = VOF_EXT_MIN;
      hi = VOF_EXT_MAX;
    end else if (rs == VOF_RNG_ITU) begin
      lo = VOF_ITU_MIN;
      hi = luma ? VOF_Y_MAX : VOF_C_MAX;
    end
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  vof_pix_t  p444;
  vof_pix_t  p422;
  logic      code_on;
  logic      chroma_cr_q;
  vof_word_t cr_hold_q;

  assign p444    = dly_q[VOF_LAT_444-1];
  // filter centre adds one stage, output register one more: 14 + 1 + 24 + 1
  assign p422    = q422_q[VOF_LAT_422-VOF_HB_CENTER-2];
  assign code_on = (st_q == VOF_ST_CODE);

  // chroma phase restarts on Cb with the last word of each start code
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chroma_cr_q <= 1'b0;
      cr_hold_q   <= VOF_CODE_ZERO;
    end else if (pix_stb) begin
      if (code_on && (word_q == VOF_CODE_LAST) && !eav_q) begin
        chroma_cr_q <= 1'b0;
      end else begin
        chroma_cr_q <= ~chroma_cr_q;
      end
      if (!chroma_cr_q) begin
        cr_hold_q <= p422.r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      grn_out                <= VOF_CODE_ZERO;
      blue_output_port       <= VOF_CODE_ZERO;
      red_out                <= VOF_CODE_ZERO;
      red_oe                 <= 1'b0;
      horizontal_sync_output <= 1'b0;
    end else if (pix_stb) begin
      horizontal_sync_output <= hs_sh_q[VOF_LAT_HS-1];
      if (cfg.mode422) begin
        grn_out          <= code_on ? code_word : vof_clamp(p422.g, cfg.range_sel, 1'b1);
        blue_output_port <= vof_clamp(chroma_cr_q ? cr_hold_q : p422.b, cfg.range_sel, 1'b0);
        red_out          <= VOF_CODE_ZERO;
        red_oe           <= 1'b0;
      end else begin
        grn_out          <= code_on ? code_word : vof_clamp(p444.g, cfg.range_sel, 1'b1);
        blue_output_port <= vof_clamp(p444.b, cfg.range_sel, 1'b0);
        red_out          <= vof_clamp(p444.r, cfg.range_sel, 1'b0);
        red_oe           <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  red_hiz_a: assert property (pix_stb && cfg.mode422 |=> !red_oe)
    else $error("red port driven in 4:2:2 mode");
  code_pre_a: assert property (pix_stb && code_on && word_q == 2'h0 |=> grn_out == 10'h3ff)
    else $error("timing code preamble not all ones");
  code_zero_a: assert property (pix_stb && code_on && word_q == 2'h1 |=> grn_out == 10'h000)
    else $error("timing code second word not zero");
  line_pos_a: assert property (pix_stb && code_on && word_q == 2'h3 |=>
    grn_out[9] && grn_out[6] == $past(eav_q) && grn_out[1:0] == 2'b00)
    else $error("status word line-position bit wrong");
  prot_bits_a: assert property (pix_stb && code_on && word_q == 2'h3 |=>
    grn_out[5] == (grn_out[7] ^ grn_out[6]) && grn_out[4] == (grn_out[8] ^ grn_out[6]) &&
    grn_out[3] == (grn_out[8] ^ grn_out[7]) && grn_out[2] == (grn_out[8] ^ grn_out[7] ^ grn_out[6]))
    else $error("protection bits inconsistent");
  code_start_a: assert property (pix_stb && !code_on && cfg.embed_en && active_video_window_d != active_video_window |=>
    code_on && word_q == 2'h0 && eav_q == $past(active_video_window))
    else $error("timing code not started at window edge");
  tap_444_a: assert property (pix_stb && !cfg.mode422 && cfg.range_sel == 2'h0 |=>
    red_out == $past(dly_q[17].r) && blue_output_port == $past(dly_q[17].b))
    else $error("4:4:4 output not from the 18th stage");
  hs_lag_a: assert property (pix_stb |=> horizontal_sync_output == $past(hs_sh_q[4]))
    else $error("horizontal sync lag wrong");
  ext_range_a: assert property (pix_stb && cfg.range_sel == 2'h1 && !code_on |=>
    grn_out >= 10'h004 && grn_out <= 10'h3fb)
    else $error("extended range clamp violated");
  itu_chroma_a: assert property (pix_stb && cfg.range_sel == 2'h2 |=>
    blue_output_port >= 10'h040 && blue_output_port <= 10'h3c0)
    else $error("chroma range clamp violated");
  cb_first_a: assert property (pix_stb && code_on && word_q == 2'h3 && !eav_q |=> !chroma_cr_q)
    else $error("chroma did not restart on Cb");
  sav_seen_c: cover property (pix_stb && code_on && word_q == 2'h3 && !eav_q);
  eav_seen_c: cover property (pix_stb && code_on && word_q == 2'h3 && eav_q);
  mode422_c:  cover property (pix_stb && cfg.mode422 && code_on);
  wrap_c:     cover property (pix_stb && stop_q < start_q && active_video_window_d);
endmodule // vof_formatter
`default_nettype wire

// *** vof_pkg.sv ***
// shared constants and types of the video output formatter
`default_nettype none
package vof_pkg;
  // ----------------------------------------------------------------
  // data carriers
  // ----------------------------------------------------------------
  typedef logic [9:0] vof_word_t;
  typedef struct packed {
    vof_word_t r;
    vof_word_t g;
    vof_word_t b;
  } vof_pix_t;
  typedef struct packed {
    logic       embed_en;
    logic       mode422;
    logic [1:0] range_sel;
  } vof_cfg_t;
  typedef enum logic {VOF_ST_IDLE, VOF_ST_CODE} vof_state_t;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VOF_ADDR_FMT      = 8'h15;
  localparam logic [7:0] VOF_ADDR_START_LO = 8'h40;
  localparam logic [7:0] VOF_ADDR_START_HI = 8'h41;
  localparam logic [7:0] VOF_ADDR_STOP_LO  = 8'h42;
  localparam logic [7:0] VOF_ADDR_STOP_HI  = 8'h43;
  localparam logic [7:0] VOF_ADDR_VST_F0   = 8'h44;
  localparam logic [7:0] VOF_ADDR_VST_F1   = 8'h45;
  localparam logic [7:0] VOF_ADDR_VDUR_F0  = 8'h46;
  localparam logic [7:0] VOF_ADDR_VDUR_F1  = 8'h47;
  localparam logic [7:0] VOF_ADDR_FST_F0   = 8'h48;
  localparam logic [7:0] VOF_ADDR_FST_F1   = 8'h49;
  localparam logic [7:0]  VOF_RST_FMT   = 8'h04;
  localparam logic [15:0] VOF_RST_START = 16'h012c;
  localparam logic [15:0] VOF_RST_STOP  = 16'h062c;
  localparam logic [7:0]  VOF_RST_VST   = 8'h05;
  localparam logic [7:0]  VOF_RST_VDUR  = 8'h1e;
  localparam logic [7:0]  VOF_RST_FST   = 8'h00;
  localparam int VOF_FMT_EMB_BIT   = 0;
  localparam int VOF_FMT_MODE_BIT  = 1;
  localparam int VOF_FMT_RANGE_LSB = 6;

  // ----------------------------------------------------------------
  // timing, coding ranges, filter
  // ----------------------------------------------------------------
  localparam int VOF_LAT_444    = 18;
  localparam int VOF_LAT_422    = 39;
  localparam int VOF_LAT_HS     = 5;
  localparam int VOF_PDELAY_TYP = 27;
  localparam int VOF_HB_TAPS    = 27;
  localparam int VOF_HB_CENTER  = 13;
  localparam int VOF_HB_PAIRS   = 7;
  localparam int VOF_HB_SHIFT   = 10;
  localparam int VOF_CODE_WORDS = 4;
  localparam logic [1:0] VOF_CODE_LAST = 2'h3;
  localparam vof_word_t  VOF_CODE_ONES = 10'h3ff;
  localparam vof_word_t  VOF_CODE_ZERO = 10'h000;
  localparam logic [1:0] VOF_RNG_FULL = 2'h0;
  localparam logic [1:0] VOF_RNG_EXT  = 2'h1;
  localparam logic [1:0] VOF_RNG_ITU  = 2'h2;
  localparam vof_word_t  VOF_EXT_MIN = 10'h004;
  localparam vof_word_t  VOF_EXT_MAX = 10'h3fb;
  localparam vof_word_t  VOF_ITU_MIN = 10'h040;
  localparam vof_word_t  VOF_Y_MAX   = 10'h3ac;
  localparam vof_word_t  VOF_C_MAX   = 10'h3c0;
  localparam logic signed [11:0] VOF_HB_MID = 12'sh200;
  localparam logic signed [11:0] VOF_HB_COEF [VOF_HB_PAIRS] =
    '{12'sh140, -12'sh061, 12'sh032, -12'sh01c, 12'sh00f, -12'sh007, 12'sh003};
endpackage
`default_nettype wire

// *** vof_halfband.sv ***
// half-band chroma decimation filter, combinational over a tap window
`default_nettype none
module vof_halfband
  import vof_pkg::*;
(
  input  wire logic [VOF_HB_TAPS-1:0][9:0] taps,
  output logic      [9:0]                  filt
);
  // ----------------------------------------------------------------
  // symmetric pairs: only odd distances carry weight in a half-band
  // ----------------------------------------------------------------
  logic signed [25:0] acc [VOF_HB_PAIRS+1];
  logic signed [25:0] rnd;
  assign acc[0] = 26'(signed'({1'b0, taps[VOF_HB_CENTER]}) * VOF_HB_MID);
  for (genvar i = 0; i < VOF_HB_PAIRS; i++) begin : g_pair
    logic [10:0] pair_sum;
    assign pair_sum = {1'b0, taps[VOF_HB_CENTER-(2*i+1)]} + {1'b0, taps[VOF_HB_CENTER+(2*i+1)]};
    assign acc[i+1] = acc[i] + 26'(signed'({1'b0, pair_sum}) * VOF_HB_COEF[i]);
  end
  assign rnd = (acc[VOF_HB_PAIRS] + 26'sd512) >>> VOF_HB_SHIFT;
  // overshoot of negative taps is clipped rather than wrapped
  always_comb begin
    if (rnd < 26'sd0) begin
      filt = VOF_CODE_ZERO;
    end else if (rnd > 26'sd1023) begin
      filt = VOF_CODE_ONES;
    end else begin
      filt = rnd[9:0];
    end
  end
endmodule // vof_halfband
`default_nettype wire

// *** vof_sink.sv ***
// downstream video processor model latching the formatter outputs
`default_nettype none
module vof_sink
  import vof_pkg::*;
(
  input wire logic      output_pixel_clock,
  input wire vof_word_t grn,
  input wire vof_word_t blu,
  input wire vof_word_t red,
  input wire logic      win,
  input wire logic      hs
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // capture history, one entry per pixel clock rise
  // ----------------------------------------------------------------
  vof_word_t cap_g [8192];
  vof_word_t cap_b [8192];
  vof_word_t cap_r [8192];
  logic      cap_w [8192];
  logic      cap_h [8192];
  int        n = 0;
  // latch on the rise: outputs changed at the previous strobe and are settled
  always @(posedge output_pixel_clock) begin
    cap_g[n] = grn;
    cap_b[n] = blu;
    cap_r[n] = red;
    cap_w[n] = win;
    cap_h[n] = hs;
    n = n + 1;
  end
endmodule // vof_sink
`default_nettype wire

// *** vof_formatter_tb_top.sv ***
// self-checking bench of the video output formatter
`default_nettype none
module vof_formatter_tb_top import vof_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic       sys_clk = 0, rst = 1, pclk = 0, hs_in = 0, vs_in = 0;
  logic       fld_in = 1, reg_wr = 0, ramp = 1, red_oe, hso, win;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  vof_pix_t   pix = '0;
  vof_word_t  grn, blu, red, gc = '0, bc = '0, rc = '0;
  wire vof_word_t red_pin;
  int         m = 0, div = 0, err_count = 0, total_checks = 0;

  initial forever #50 sys_clk = ~sys_clk;
  // pixel clock of 8 system clocks; lines of 64 pixels, frames of 8 lines
  always @(posedge sys_clk) begin
    div <= (div + 1) % 8;
    if (div == 3) pclk <= 1'b0;
    if (div == 7) begin
      pclk <= 1'b1;
      pix <= '{r: ramp ? 10'(200 + m % 256) : rc, g: ramp ? 10'(100 + m % 256) : gc, b: bc};
      hs_in <= (m % 64) < 4;
      vs_in <= (m % 512) < 64;
      m <= m + 1;
    end
  end
  vof_formatter vof_formatter_i (.sys_clk(sys_clk), .rst(rst), .output_pixel_clock(pclk), .pix_in(pix),
    .hsync_in(hs_in), .vsync_in(vs_in), .field_in(fld_in), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .grn_out(grn), .blue_output_port(blu), .red_out(red),
    .red_oe(red_oe), .horizontal_sync_output(hso), .active_video_window(win));
  // the red pins float when the formatter lets go of them
  assign red_pin = red_oe ? red : 10'hzzz;
  vof_sink vof_sink_i (.output_pixel_clock(pclk), .grn(grn), .blu(blu), .red(red_pin), .win(win), .hs(hso));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input vof_word_t exp, input vof_word_t got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 chk($sformatf("reg %h", a), {2'b00, exp}, {2'b00, reg_rdata});
  endtask
  // ends just after an edge so that outputs launched there have landed
  task automatic wait_pix(input int n);
    repeat (n * 8) @(posedge sys_clk);
    #1;
  endtask
  function automatic vof_word_t st_w(logic f, logic v, logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
  endfunction
  // line of the input pixel at position p that produced capture k
  function automatic int lin(int k, int p);
    return ((k - (k - p) % 64) % 512) / 64;
  endfunction
  task automatic code4(input int k, input vof_word_t s);
    chk("code word 0", 10'h3ff, vof_sink_i.cap_g[k + 1]);
    chk("code word 1", 10'h000, vof_sink_i.cap_g[k + 2]);
    chk("code word 2", 10'h000, vof_sink_i.cap_g[k + 3]);
    chk("status word", s, vof_sink_i.cap_g[k + 4]);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(VOF_ADDR_FMT, VOF_RST_FMT);
    rd(VOF_ADDR_START_LO, VOF_RST_START[7:0]);
    rd(VOF_ADDR_START_HI, VOF_RST_START[15:8]);
    rd(VOF_ADDR_STOP_LO, VOF_RST_STOP[7:0]);
    rd(VOF_ADDR_STOP_HI, VOF_RST_STOP[15:8]);
    rd(VOF_ADDR_VST_F0, VOF_RST_VST);
    rd(VOF_ADDR_VST_F1, VOF_RST_VST);
    rd(VOF_ADDR_VDUR_F0, VOF_RST_VDUR);
    rd(VOF_ADDR_VDUR_F1, VOF_RST_VDUR);
    rd(VOF_ADDR_FST_F0, VOF_RST_FST);
    rd(VOF_ADDR_FST_F1, VOF_RST_FST);
    wr(8'h50, 8'h5a);
    rd(8'h50, 8'h00);
    wr(VOF_ADDR_VST_F1, 8'h02);
    wr(VOF_ADDR_VDUR_F1, 8'h03);
    rd(VOF_ADDR_VDUR_F1, 8'h03);
  endtask
  task automatic t_444();
    int j0;
    wr(VOF_ADDR_FMT, 8'h00);
    bc <= 10'h155;
    wait_pix(40);
    j0 = m + 62 - m % 64;
    wait_pix(100);
    chk("red_oe", 10'h001, {9'h000, red_oe});
    for (int j = j0; j < j0 + 8; j++) begin
      chk("grn 444", 10'(100 + j % 256), vof_sink_i.cap_g[j + 19]);
      chk("red 444", 10'(200 + j % 256), vof_sink_i.cap_r[j + 19]);
      chk("blu 444", 10'h155, vof_sink_i.cap_b[j + 19]);
      chk("hsync out", {9'h000, (j % 64) < 4}, {9'h000, vof_sink_i.cap_h[j + 6]});
    end
  endtask
  task automatic t_range();
    vof_word_t hy [4] = '{10'h3ff, 10'h3fb, 10'h3ac, 10'h3ff};
    vof_word_t hc [4] = '{10'h3ff, 10'h3fb, 10'h3c0, 10'h3ff};
    vof_word_t lo [4] = '{10'h000, 10'h004, 10'h040, 10'h000};
    ramp <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      wr(VOF_ADDR_FMT, 8'(s << 6));
      for (int h = 0; h < 2; h++) begin
        {gc, bc, rc} <= {3{h ? 10'h3ff : 10'h000}};
        wait_pix(25);
        chk("grn clamp", h ? hy[s] : lo[s], grn);
        chk("blu clamp", h ? hc[s] : lo[s], blu);
        chk("red clamp", h ? hc[s] : lo[s], red);
      end
    end
  endtask
  task automatic t_422();
    int j0;
    ramp <= 1'b1;
    wr(VOF_ADDR_FMT, 8'h42);
    wait_pix(100);
    j0 = m;
    wait_pix(60);
    chk("red_oe", 10'h000, {9'h000, red_oe});
    for (int j = j0; j < j0 + 8; j++) begin
      chk("grn 422", 10'(100 + j % 256), vof_sink_i.cap_g[j + 40]);
      chk("red float", 10'hzzz, vof_sink_i.cap_r[j + 40]);
    end
  endtask
  // one full frame of timing codes; a late start makes the stop wrap
  task automatic t_codes(input int st);
    int sp, a, kf, nr;
    sp = st + 8 + 4;
    if (sp > 64) sp = sp - 64;
    wr(VOF_ADDR_FMT, 8'h43);
    wr(VOF_ADDR_START_LO, 8'(st));
    wr(VOF_ADDR_START_HI, 8'h00);
    wr(VOF_ADDR_STOP_LO, 8'(sp));
    wr(VOF_ADDR_STOP_HI, 8'h00);
    ramp <= 1'b0;
    {gc, bc, rc} <= {10'h1f4, 10'h064, 10'h0c8};
    wait_pix(520);
    a = m;
    nr = 0;
    wait_pix(600);
    for (int k = a; k < a + 512; k++) begin
      if (vof_sink_i.cap_w[k] === 1'b1 && vof_sink_i.cap_w[k - 1] === 1'b0) begin
        nr++;
        kf = k;
        while (vof_sink_i.cap_w[kf] === 1'b1 && kf < k + 64) kf++;
        chk("window width", 10'd12, 10'(kf - k));
        code4(k, st_w(1'b1, lin(k, st) inside {[2:4]}, 1'b0));
        code4(kf, st_w(1'b1, lin(kf, sp) inside {[2:4]}, 1'b1));
        chk("first chroma", 10'h064, vof_sink_i.cap_b[k + 5]);
        chk("second chroma", 10'h0c8, vof_sink_i.cap_b[k + 6]);
      end
    end
    chk("windows per frame", 10'd8, 10'(nr));
  endtask

  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_444();
    t_range();
    t_422();
    t_codes(8);
    t_codes(60);
    give_verdict();
  end
  // the sequence needs about 22000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
endmodule // vof_formatter_tb_top
`default_nettype wire
